// *** src/sdrci_core.sv ***
// command-level behaviour of a four-bank synchronous dram
// ==========================================================
`default_nettype none
module sdrci_core (
    input wire logic clk,                                   // device clock
    input wire logic srst,                                  // sync reset, high
    input wire logic chip_select_n,                         // chip select, low
    input wire logic row_strobe_n,                          // row strobe, low
    input wire logic col_strobe_n,                          // column strobe, low
    input wire logic write_enable_n,                        // write enable, low
    input wire logic clock_enable,                          // clock enable
    input wire logic bank_select_bit0,                      // bank select 0
    input wire logic bank_select_bit1,                      // bank select 1
    input wire logic [sdrci_pkg::ROW_W-1:0] addr,           // address inputs
    input wire logic [sdrci_pkg::NLANE-1:0] data_mask,      // per-lane mask
    input wire logic [sdrci_pkg::DQ_W-1:0] dq_in,           // data in
    output logic [sdrci_pkg::DQ_W-1:0] dq_out,              // read data out
    output logic [sdrci_pkg::NLANE-1:0] dq_oe,              // per-lane drive
    output logic [sdrci_pkg::MODE_W-1:0] mode_opcode,       // mode register
    output logic [sdrci_pkg::NBANK-1:0] bank_open,          // row open flags
    output logic self_refresh_active,                       // in self refresh
    output logic [sdrci_pkg::ROW_W-1:0] refresh_row         // refresh counter
);
    // ==========================================================
    // decode
    sdrci_pkg::sdrci_cmd_e cmd;
    sdrci_decode u_decode (
        .chip_select_n(chip_select_n),
        .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n),
        .write_enable_n(write_enable_n),
        .clock_enable(clock_enable),
        .cmd(cmd)
    );
    // self refresh blinds every command input except clock_enable, which ends it
    logic live;
    assign live = !self_refresh_active;
    logic [sdrci_pkg::BANK_W-1:0] bank_sel;
    assign bank_sel = {bank_select_bit1, bank_select_bit0};

    // ==========================================================
    // state
    logic [sdrci_pkg::MODE_W-1:0] mode_ff, nxt_mode;
    logic [sdrci_pkg::NBANK-1:0] open_ff, nxt_open;
    logic [sdrci_pkg::ROW_W-1:0] row_ff [sdrci_pkg::NBANK];
    logic [sdrci_pkg::ROW_W-1:0] nxt_row [sdrci_pkg::NBANK];
    logic [sdrci_pkg::ROW_W-1:0] ref_ff, nxt_ref;
    logic sref_ff, nxt_sref;
    logic [7:0] stick_ff, nxt_stick;
    sdrci_pkg::sdrci_burst_e burst_ff, nxt_burst;
    logic [3:0] left_ff, nxt_left;
    logic ap_ff, nxt_ap;
    logic [sdrci_pkg::BANK_W-1:0] bbank_ff, nxt_bbank;
    logic [sdrci_pkg::MEM_AW-1:0] col_ff, nxt_col;
    logic [sdrci_pkg::DQ_W-1:0] rdat_ff [sdrci_pkg::READ_MASK_LAT];
    logic [sdrci_pkg::DQ_W-1:0] nxt_rdat [sdrci_pkg::READ_MASK_LAT];
    logic [sdrci_pkg::READ_MASK_LAT-1:0] rval_ff, nxt_rval;
    logic [sdrci_pkg::NLANE-1:0] rmask_ff [sdrci_pkg::READ_MASK_LAT];
    logic [sdrci_pkg::NLANE-1:0] nxt_rmask [sdrci_pkg::READ_MASK_LAT];

    // small array; index folds bank and low column bits
    logic [sdrci_pkg::DQ_W-1:0] mem [sdrci_pkg::MEM_DEPTH];

    function automatic logic [sdrci_pkg::MEM_AW-1:0] mem_index(
        input logic [sdrci_pkg::BANK_W-1:0] b,
        input logic [sdrci_pkg::MEM_AW-1:0] c
    );
        mem_index = {b, c[sdrci_pkg::MEM_AW-sdrci_pkg::BANK_W-1:0]};
    endfunction : mem_index

    // ==========================================================
    // command and bank state
    logic burst_on, starting, stopping, wr_beat, rd_beat;
    always_comb begin
        nxt_mode = mode_ff;
        nxt_open = open_ff;
        nxt_row = row_ff;
        nxt_ref = ref_ff;
        nxt_sref = sref_ff;
        nxt_stick = stick_ff;
        nxt_burst = burst_ff;
        nxt_left = left_ff;
        nxt_ap = ap_ff;
        nxt_bbank = bbank_ff;
        nxt_col = col_ff;
        burst_on = (burst_ff != sdrci_pkg::SDRCI_BURST_IDLE);
        starting = 1'b0;
        stopping = 1'b0;
        // burst progress; auto precharge closes the row at the end
        if (burst_on) begin
            nxt_col = col_ff + 8'h01;
            nxt_left = left_ff - 4'h1;
            if (left_ff == 4'h1) begin
                nxt_burst = sdrci_pkg::SDRCI_BURST_IDLE;
                if (ap_ff) begin
                    nxt_open[bbank_ff] = 1'b0;
                end
            end
        end
        if (sref_ff) begin
            // own timer refreshes rows with no commands needed
            nxt_stick = stick_ff - 8'h01;
            if (stick_ff == 8'h00) begin
                nxt_stick = sdrci_pkg::SELF_REF_CNT - 8'h01;
                nxt_ref = ref_ff + 13'h0001;
            end
            if (clock_enable) begin
                nxt_sref = 1'b0;
            end
        end else if (live) begin
            case (cmd)
                sdrci_pkg::SDRCI_CMD_MRL: begin
                    nxt_mode = addr[sdrci_pkg::MODE_W-1:0];
                end
                sdrci_pkg::SDRCI_CMD_ACTIVE: begin
                    nxt_open[bank_sel] = 1'b1;
                    nxt_row[bank_sel] = addr;
                end
                sdrci_pkg::SDRCI_CMD_READ, sdrci_pkg::SDRCI_CMD_WRITE: begin
                    starting = 1'b1;
                    nxt_burst = (cmd == sdrci_pkg::SDRCI_CMD_READ)
                        ? sdrci_pkg::SDRCI_BURST_READ : sdrci_pkg::SDRCI_BURST_WRITE;
                    nxt_bbank = bank_sel;
                    nxt_col = addr[sdrci_pkg::MEM_AW-1:0] + 8'h01;
                    nxt_ap = addr[sdrci_pkg::AP_BIT];
                    nxt_left = sdrci_pkg::BURST_LEN_CNT - 4'h1;
                end
                sdrci_pkg::SDRCI_CMD_BST: begin
                    stopping = 1'b1;
                    nxt_burst = sdrci_pkg::SDRCI_BURST_IDLE;
                    nxt_left = 4'h0;
                end
                sdrci_pkg::SDRCI_CMD_PRE: begin
                    if (addr[sdrci_pkg::AP_BIT]) begin
                        nxt_open = '0;
                    end else begin
                        nxt_open[bank_sel] = 1'b0;
                    end
                end
                sdrci_pkg::SDRCI_CMD_AREF: begin
                    nxt_ref = ref_ff + 13'h0001;
                end
                sdrci_pkg::SDRCI_CMD_SREF: begin
                    nxt_sref = 1'b1;
                    nxt_stick = sdrci_pkg::SELF_REF_CNT - 8'h01;
                end
                default: begin
                    nxt_mode = mode_ff;
                end
            endcase
        end
        // terminate edge carries no beat; a new command replaces the old burst
        wr_beat = starting ? (cmd == sdrci_pkg::SDRCI_CMD_WRITE)
                           : (burst_ff == sdrci_pkg::SDRCI_BURST_WRITE && !stopping);
        rd_beat = starting ? (cmd == sdrci_pkg::SDRCI_CMD_READ)
                           : (burst_ff == sdrci_pkg::SDRCI_BURST_READ && !stopping);
    end

    logic [sdrci_pkg::MEM_AW-1:0] beat_idx;
    assign beat_idx = starting ? mem_index(bank_sel, addr[sdrci_pkg::MEM_AW-1:0])
                               : mem_index(bbank_ff, col_ff);

    // ==========================================================
    // read pipeline; mask taken with the beat, applied two cycles on
    always_comb begin
        nxt_rval = {rval_ff[sdrci_pkg::READ_MASK_LAT-2:0], rd_beat};
        nxt_rdat[0] = mem[beat_idx];
        nxt_rmask[0] = data_mask;
        for (int i = 1; i < sdrci_pkg::READ_MASK_LAT; i++) begin
            nxt_rdat[i] = rdat_ff[i-1];
            nxt_rmask[i] = rmask_ff[i-1];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff <= sdrci_pkg::MODE_RST;
            open_ff <= '0;
            ref_ff <= sdrci_pkg::REF_ROW_RST;
            sref_ff <= 1'b0;
            stick_ff <= 8'h00;
            burst_ff <= sdrci_pkg::SDRCI_BURST_IDLE;
            left_ff <= 4'h0;
            ap_ff <= 1'b0;
            bbank_ff <= '0;
            col_ff <= '0;
            rval_ff <= '0;
            for (int i = 0; i < sdrci_pkg::NBANK; i++) begin
                row_ff[i] <= '0;
            end
            for (int i = 0; i < sdrci_pkg::READ_MASK_LAT; i++) begin
                rdat_ff[i] <= '0;
                rmask_ff[i] <= '1;
            end
        end else begin
            mode_ff <= nxt_mode;
            open_ff <= nxt_open;
            row_ff <= nxt_row;
            ref_ff <= nxt_ref;
            sref_ff <= nxt_sref;
            stick_ff <= nxt_stick;
            burst_ff <= nxt_burst;
            left_ff <= nxt_left;
            ap_ff <= nxt_ap;
            bbank_ff <= nxt_bbank;
            col_ff <= nxt_col;
            rval_ff <= nxt_rval;
            rdat_ff <= nxt_rdat;
            rmask_ff <= nxt_rmask;
        end
    end

    // ==========================================================
    // write lanes; masked lanes keep their old contents
    // one process owns the array, so lanes share it without two writers
    always_ff @(posedge clk) begin
        for (int l = 0; l < sdrci_pkg::NLANE; l++) begin
            if (wr_beat && live && !data_mask[l]) begin
                mem[beat_idx][l*sdrci_pkg::LANE_W +: sdrci_pkg::LANE_W]
                    <= dq_in[l*sdrci_pkg::LANE_W +: sdrci_pkg::LANE_W];
            end
        end
    end
    genvar g;
    generate
        for (g = 0; g < sdrci_pkg::NLANE; g++) begin : g_lane
            assign dq_oe[g] = rval_ff[sdrci_pkg::READ_MASK_LAT-1]
                              && !rmask_ff[sdrci_pkg::READ_MASK_LAT-1][g];
        end
    endgenerate

    assign dq_out = rdat_ff[sdrci_pkg::READ_MASK_LAT-1];
    assign mode_opcode = mode_ff;
    assign bank_open = open_ff;
    assign self_refresh_active = sref_ff;
    assign refresh_row = ref_ff;
endmodule : sdrci_core
`default_nettype wire

// *** src/sdrci_pkg.sv ***
// package of constants and types for the sdram command interface
`default_nettype none
package sdrci_pkg;
    // ==========================================================
    // geometry
    localparam int BANK_W = 2;
    localparam int NBANK = 4;
    localparam int ROW_W = 13;
    localparam int COL_W = 10;
    localparam int MODE_W = 12;
    localparam int DQ_W = 16;
    localparam int LANE_W = 8;
    localparam int NLANE = 2;
    localparam int AP_BIT = 10;
    localparam int MEM_DEPTH = 256;
    localparam int MEM_AW = 8;
    // ==========================================================
    // reset values and timing
    localparam logic [MODE_W-1:0] MODE_RST = 12'h000;
    localparam logic [ROW_W-1:0] REF_ROW_RST = 13'h0000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int READ_MASK_LAT = 2;
    localparam int BURST_LEN = 4;
    localparam logic [3:0] BURST_LEN_CNT = 4'h4;
    // internal self refresh interval in ns, counted in device clocks
    localparam int SELF_REF_INT_NS = 7813;
    localparam int SELF_REF_CYC = SELF_REF_INT_NS / CLK_PERIOD_NS;
    localparam logic [7:0] SELF_REF_CNT = 8'(SELF_REF_CYC);
    // ==========================================================
    // decoded commands
    typedef enum logic [3:0] {
        SDRCI_CMD_INHIBIT = 4'h0,
        SDRCI_CMD_NOP = 4'h1,
        SDRCI_CMD_ACTIVE = 4'h2,
        SDRCI_CMD_READ = 4'h3,
        SDRCI_CMD_WRITE = 4'h4,
        SDRCI_CMD_BST = 4'h5,
        SDRCI_CMD_PRE = 4'h6,
        SDRCI_CMD_AREF = 4'h7,
        SDRCI_CMD_SREF = 4'h8,
        SDRCI_CMD_MRL = 4'h9
    } sdrci_cmd_e;
    typedef enum logic [1:0] {
        SDRCI_BURST_IDLE = 2'b00,
        SDRCI_BURST_READ = 2'b01,
        SDRCI_BURST_WRITE = 2'b10
    } sdrci_burst_e;
endpackage : sdrci_pkg
`default_nettype wire

// *** src/sdrci_decode.sv ***
// command decoder for the sdram command interface
`default_nettype none
module sdrci_decode (
    input wire logic chip_select_n,           // active low select
    input wire logic row_strobe_n,            // row strobe
    input wire logic col_strobe_n,            // column strobe
    input wire logic write_enable_n,          // write enable
    input wire logic clock_enable,            // clock enable
    output var sdrci_pkg::sdrci_cmd_e cmd     // decoded command
);
    always_comb begin
        cmd = sdrci_pkg::SDRCI_CMD_INHIBIT;
        if (chip_select_n) begin
            cmd = sdrci_pkg::SDRCI_CMD_INHIBIT;
        end else begin
            case ({row_strobe_n, col_strobe_n, write_enable_n})
                3'b111: cmd = sdrci_pkg::SDRCI_CMD_NOP;
                3'b011: cmd = sdrci_pkg::SDRCI_CMD_ACTIVE;
                3'b101: cmd = sdrci_pkg::SDRCI_CMD_READ;
                3'b100: cmd = sdrci_pkg::SDRCI_CMD_WRITE;
                3'b110: cmd = sdrci_pkg::SDRCI_CMD_BST;
                3'b010: cmd = sdrci_pkg::SDRCI_CMD_PRE;
                3'b001: begin
                    cmd = clock_enable ? sdrci_pkg::SDRCI_CMD_AREF
                                       : sdrci_pkg::SDRCI_CMD_SREF;
                end
                default: cmd = sdrci_pkg::SDRCI_CMD_MRL;
            endcase
        end
    end
endmodule : sdrci_decode
`default_nettype wire

// *** bench/sdrci_checker.sv ***
// port assertions for the command interface core
`default_nettype none
module sdrci_checker (
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic chip_select_n, // select, low
    input wire logic row_strobe_n, // row strobe
    input wire logic col_strobe_n, // column strobe
    input wire logic write_enable_n, // write enable
    input wire logic clock_enable, // clock enable
    input wire logic bank_select_bit0, // bank 0
    input wire logic bank_select_bit1, // bank 1
    input wire logic [12:0] addr, // address
    input wire logic [1:0] data_mask, // lane mask
    input wire logic [1:0] dq_oe, // lane drive
    input wire logic [11:0] mode_opcode, // mode
    input wire logic [3:0] bank_open, // open rows
    input wire logic self_refresh_active, // self refresh
    input wire logic [12:0] refresh_row // refresh row
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================================
    // decoded pins
    logic [2:0] op;
    logic live;
    logic [1:0] bk;
    assign op = {row_strobe_n, col_strobe_n, write_enable_n};
    assign live = !chip_select_n && !self_refresh_active;
    assign bk = {bank_select_bit1, bank_select_bit0};
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    a_deselect_holds_state: assert property (chip_select_n && !self_refresh_active
        |=> $stable(mode_opcode) && $stable(refresh_row)) else $error("state moved while deselected");
    a_mode_load_value: assert property (live && clock_enable && op == 3'h0
        |=> mode_opcode == $past(addr[11:0])) else $error("mode opcode not loaded");
    a_activate_opens_bank: assert property (live && op == 3'h3
        |=> bank_open[$past(bk)]) else $error("activate left bank closed");
    a_precharge_one_bank: assert property (live && op == 3'h2 && !addr[10]
        |=> !bank_open[$past(bk)]) else $error("single precharge left bank open");
    a_precharge_all_banks: assert property (live && op == 3'h2 && addr[10]
        |=> bank_open == 4'h0) else $error("precharge all left a bank open");
    a_read_mask_hiz: assert property (dq_oe != 2'h0
        |-> (dq_oe & $past(data_mask, 2)) == 2'h0) else $error("masked lane driven");
    a_auto_pre_close: assert property (live && op[2:1] == 2'h2 && addr[10]
        |-> ##4 !bank_open[$past(bk, 4)]) else $error("auto precharge kept row open");
    a_terminate_stops_beats: assert property (live && op == 3'h6
        |-> ##2 dq_oe == 2'h0) else $error("beat after burst terminate");
    a_auto_refresh_step: assert property (live && clock_enable && op == 3'h1
        |=> refresh_row == $past(refresh_row) + 13'h0001) else $error("refresh row not stepped");
    a_self_entry_taken: assert property (live && !clock_enable && op == 3'h1
        |=> self_refresh_active) else $error("self refresh not entered");
    a_self_ignores_pins: assert property (self_refresh_active && !clock_enable
        |=> self_refresh_active && $stable(bank_open)) else $error("pins obeyed in self refresh");
endmodule : sdrci_checker
bind sdrci_core sdrci_checker i_checker (.clk(clk), .srst(srst), .chip_select_n(chip_select_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
    .clock_enable(clock_enable), .bank_select_bit0(bank_select_bit0),
    .bank_select_bit1(bank_select_bit1), .addr(addr), .data_mask(data_mask), .dq_oe(dq_oe),
    .mode_opcode(mode_opcode), .bank_open(bank_open),
    .self_refresh_active(self_refresh_active), .refresh_row(refresh_row));
`default_nettype wire

// *** bench/sdrci_ctrl_model.sv ***
// memory controller model driving the command pins
`default_nettype none
module sdrci_ctrl_model (
    input wire logic clk, // device clock
    output logic chip_select_n, // select, low
    output logic row_strobe_n, // row strobe
    output logic col_strobe_n, // column strobe
    output logic write_enable_n, // write enable
    output logic clock_enable, // clock enable
    output logic bank_select_bit0, // bank 0
    output logic bank_select_bit1, // bank 1
    output logic [12:0] addr, // address
    output logic [1:0] data_mask, // lane mask
    output logic [15:0] dq_in // write data
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        chip_select_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_enable_n} = 3'h7;
        clock_enable = 1'b1;
        {bank_select_bit1, bank_select_bit0} = 2'h0;
        addr = 13'h0000;
        data_mask = 2'h0;
        dq_in = 16'h0000;
    end
    // one command per cycle, driven just after the edge
    task automatic issue(input logic [2:0] op, input logic [1:0] b, input logic [12:0] a,
        input logic [1:0] m, input logic [15:0] d, input logic dv, input logic ck,
        input logic cs);
        logic pad;
        pad = !cs && ck && (op == 3'h0 || !clock_enable);
        @(posedge clk);
        #1;
        chip_select_n = cs;
        {row_strobe_n, col_strobe_n, write_enable_n} = op;
        clock_enable = ck;
        {bank_select_bit1, bank_select_bit0} = b;
        addr = a;
        data_mask = m;
        // idle data toggles so a stale word never passes as written
        dq_in = dv ? d : ~dq_in;
        // mode load and self refresh exit need idle cycles after them
        if (pad) begin
            repeat (2) begin
                @(posedge clk);
                #1;
                {row_strobe_n, col_strobe_n, write_enable_n} = 3'h7;
                dq_in = ~dq_in;
            end
        end
    endtask : issue
endmodule : sdrci_ctrl_model
`default_nettype wire

// *** bench/tb.sv ***
// self-checking bench for the command interface core
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [2:0] OP_NOP = 3'h7;
    localparam logic [2:0] OP_ACT = 3'h3;
    localparam logic [2:0] OP_RD = 3'h5;
    localparam logic [2:0] OP_WR = 3'h4;
    localparam logic [2:0] OP_BST = 3'h6;
    localparam logic [2:0] OP_PRE = 3'h2;
    localparam logic [2:0] OP_REF = 3'h1;
    localparam logic [2:0] OP_MODE = 3'h0;
    logic clk, srst, cs_n, row_n, col_n, we_n, cke, ba0, ba1, sref;
    logic [12:0] a, rrow, r0;
    logic [1:0] dm, oe;
    logic [15:0] dqi, dqo;
    logic [11:0] mode;
    logic [3:0] bopen;
    logic [15:0] ew [4];
    int bad_count = 0;
    int check_count = 0;
    sdrci_ctrl_model i_ctrl (.clk(clk), .chip_select_n(cs_n), .row_strobe_n(row_n),
        .col_strobe_n(col_n), .write_enable_n(we_n), .clock_enable(cke),
        .bank_select_bit0(ba0), .bank_select_bit1(ba1), .addr(a), .data_mask(dm), .dq_in(dqi));
    sdrci_core i_dut (.clk(clk), .srst(srst), .chip_select_n(cs_n), .row_strobe_n(row_n),
        .col_strobe_n(col_n), .write_enable_n(we_n), .clock_enable(cke),
        .bank_select_bit0(ba0), .bank_select_bit1(ba1), .addr(a), .data_mask(dm), .dq_in(dqi),
        .dq_out(dqo), .dq_oe(oe), .mode_opcode(mode), .bank_open(bopen),
        .self_refresh_active(sref), .refresh_row(rrow));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        if (bad_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : summarize
    task automatic cmd(input logic [2:0] op, input logic [1:0] b, input logic [12:0] ad,
        input logic ck);
        i_ctrl.issue(op, b, ad, 2'h0, 16'h0000, 1'b0, ck, 1'b0);
    endtask : cmd
    task automatic nop(input int n);
        repeat (n) cmd(OP_NOP, 2'h0, 13'h0000, 1'b1);
    endtask : nop
    task automatic wburst(input logic [12:0] ad, input logic [7:0] m, input logic [7:0] s);
        for (int k = 0; k < 4; k++) begin
            i_ctrl.issue(k == 0 ? OP_WR : OP_NOP, 2'h1, ad, 2'(m >> (2 * k)),
                {s + 8'(k), ~s - 8'(k)}, 1'b1, 1'b1, 1'b0);
        end
    endtask : wburst
    // beat k shows two cycles after its edge; stop marks the terminate step
    task automatic rburst(input logic [12:0] ad, input logic [7:0] m, input int stop);
        logic [1:0] mk;
        for (int j = 0; j < 6; j++) begin
            i_ctrl.issue(j == 0 ? OP_RD : (j == stop ? OP_BST : OP_NOP), 2'h1, ad,
                2'(m >> (2 * j)), 16'h0000, 1'b0, 1'b1, 1'b0);
            if (j >= 2) begin
                mk = 2'(m >> (2 * (j - 2)));
                check(16'(oe), (j - 2) < stop ? {14'h0000, ~mk} : 16'h0000);
                if ((j - 2) < stop && !mk[0]) check(16'(dqo[7:0]), 16'(ew[j-2][7:0]));
                if ((j - 2) < stop && !mk[1]) check(16'(dqo[15:8]), 16'(ew[j-2][15:8]));
            end
        end
    endtask : rburst
    // ==========================================================
    // scenarios
    task automatic t_mode();
        check(16'(rrow), 16'h0000);
        i_ctrl.issue(OP_MODE, 2'h3, 13'h1A5C, 2'h3, 16'h0000, 1'b0, 1'b1, 1'b1);
        nop(1);
        check(16'(mode), 16'h0000);
        cmd(OP_MODE, 2'h0, 13'h1A5C, 1'b1);
        check(16'(mode), 16'h0A5C);
    endtask : t_mode
    task automatic t_bank();
        for (int i = 0; i < 4; i++) begin
            cmd(OP_ACT, 2'(i), 13'h0100, 1'b1);
        end
        nop(1);
        check(16'(bopen), 16'h000F);
        cmd(OP_PRE, 2'h2, 13'h0000, 1'b1);
        nop(1);
        check(16'(bopen), 16'h000B);
        cmd(OP_PRE, 2'h1, 13'h0400, 1'b1);
        nop(2);
        check(16'(bopen), 16'h0000);
    endtask : t_bank
    task automatic t_rw();
        for (int k = 0; k < 4; k++) ew[k] = {8'h40 + 8'(k), ~8'h40 - 8'(k)};
        ew[1][7:0] = ~8'h10 - 8'h01;
        ew[2][15:8] = 8'h12;
        cmd(OP_ACT, 2'h1, 13'h0100, 1'b1);
        nop(2);
        wburst(13'h0008, 8'h00, 8'h10);
        wburst(13'h0408, 8'h24, 8'h40);
        nop(1);
        check(16'(bopen), 16'h0000);
        cmd(OP_ACT, 2'h1, 13'h0100, 1'b1);
        nop(2);
        rburst(13'h0008, 8'h18, 6);
        check(16'(bopen), 16'h0002);
        rburst(13'h0008, 8'h00, 2);
        cmd(OP_PRE, 2'h0, 13'h0400, 1'b1);
        nop(2);
    endtask : t_rw
    task automatic t_ref();
        r0 = rrow;
        cmd(OP_REF, 2'h0, 13'h1FFF, 1'b1);
        nop(1);
        check(16'(rrow), 16'(r0 + 13'h0001));
        nop(4);
        // part modelled is not an automotive grade, so self refresh is legal
        cmd(OP_REF, 2'h0, 13'h0000, 1'b0);
        cmd(OP_ACT, 2'h2, 13'h0000, 1'b0);
        check(16'(sref), 16'h0001);
        r0 = rrow;
        repeat (200) cmd(OP_NOP, 2'h0, 13'h0000, 1'b0);
        check(16'(bopen), 16'h0000);
        check(16'(rrow != r0), 16'h0001);
        nop(1);
        check(16'(sref), 16'h0000);
        r0 = rrow;
        cmd(OP_REF, 2'h0, 13'h0000, 1'b1);
        nop(1);
        check(16'(rrow), 16'(r0 + 13'h0001));
    endtask : t_ref
    initial begin
        srst = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        srst = 1'b0;
        t_mode();
        t_bank();
        t_rw();
        t_ref();
        summarize();
    end
endmodule : tb
`default_nettype wire
